// ### gtc_pkg.sv
// gtc_pkg: register map, field positions and reset values of the gated
// 16-bit timer/counter; shared by the top module and its synchroniser.
package gtc_pkg;
  // byte addresses on the register bus
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h18;
  // timer_control fields
  localparam int BIT_TIMER_ON = 0;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_SYNC_DISABLE = 2;
  localparam int BIT_LP_OSC_ENABLE = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_GATE_ENABLE = 6;
  localparam int BIT_GATE_INVERT = 7;
  // other fields
  localparam int BIT_GATE_SOURCE = 1;
  localparam int BIT_ROLLOVER = 0;
  localparam int BIT_PERIPH_ENABLE = 6;
  localparam int BIT_GLOBAL_ENABLE = 7;
  // reset values and the count limit
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // instruction cycle is four system clocks
  localparam logic [1:0] QDIV_LAST = 2'h3;
  // synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int LANE_EXT_CLK = 0;
  localparam int LANE_LP_CLK = 1;
  localparam int LANE_GATE = 2;
  localparam int LANE_COMP2 = 3;
endpackage : gtc_pkg

// ### gtc_sync.sv
// gtc_sync: two-flop synchronisers for the asynchronous pin inputs.
// assumes each lane is a slow level; no gate reads the first stage.
`timescale 1ns/10ps
`default_nettype none
module gtc_sync
  import gtc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // pins in, levels out
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } gtc_sync_state_type;

  gtc_sync_state_type r;
  gtc_sync_state_type next_r;

  // per-lane two-stage chain
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_lane
      always_comb begin
        next_r.meta[i] = async_in[i];
        next_r.stable[i] = r.meta[i];
      end
    end
  endgenerate

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;
endmodule // gtc_sync
`default_nettype wire

// ### gtc_timer.sv
// gtc_timer: gated 16-bit timer/counter with prescaler, AHB-Lite slave.
// assumes a single AHB-Lite master, word transfers, one 50 MHz clock;
// sleep and oscillator mode come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // pins and comparator
  input wire logic ext_count_clock_pin_in,
  input wire logic lp_osc_clock_in,
  input wire logic gate_pin_n_in,
  input wire logic comparator_two_output_in,
  // core status
  input wire logic sleep_in,
  input wire logic internal_oscillator_no_clkout_in,
  // interrupt, wake and oscillator control
  output logic irq_out,
  output logic wake_out,
  output logic lp_osc_enable_out
);
  typedef struct packed {
    logic [7:0] timer_control;
    logic [15:0] count;
    logic [2:0] prescale;
    logic [1:0] qdiv;
    logic armed;
    logic clk_prev;
    logic sync_pend;
    logic rollover_flag;
    logic rollover_irq_enable;
    logic periph_enable;
    logic global_enable;
    logic gate_source_select;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    logic wake;
    logic lp_en;
  } gtc_state_type;

  gtc_state_type r;
  gtc_state_type next_r;
  logic [SYNC_W-1:0] pins_sync;

  // pins cross into the clock domain first
  gtc_sync u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in({comparator_two_output_in, gate_pin_n_in, lp_osc_clock_in,
               ext_count_clock_pin_in}),
    .sync_out(pins_sync)
  );

  // decoded control fields
  logic timer_on;
  logic use_ext;
  logic free_run;
  logic lp_sel;
  logic [1:0] ps_sel;
  logic gate_active;
  logic run;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic q_en;
  logic tick;
  logic [2:0] ps_last;
  logic rollover;
  logic addr_phase;
  logic wr_count;
  logic [31:0] rd_word;

  always_comb begin
    timer_on = r.timer_control[BIT_TIMER_ON];
    use_ext = r.timer_control[BIT_CLOCK_SOURCE];
    // sync bit only matters with the pin source
    free_run = use_ext & r.timer_control[BIT_SYNC_DISABLE];
    // low-power clock only with internal oscillator, no clock out
    lp_sel = r.timer_control[BIT_LP_OSC_ENABLE] & internal_oscillator_no_clkout_in;
    ps_sel = r.timer_control[BIT_PRESCALE_LO+1:BIT_PRESCALE_LO];
    // gate: pin active low or comparator, then optional invert
    gate_active = (r.gate_source_select ? pins_sync[LANE_COMP2]
                                        : ~pins_sync[LANE_GATE])
                  ^ r.timer_control[BIT_GATE_INVERT];
    // gate enable ignored while the timer is off
    run = timer_on & ~(r.timer_control[BIT_GATE_ENABLE] & gate_active);
    ext_level = lp_sel ? pins_sync[LANE_LP_CLK] : pins_sync[LANE_EXT_CLK];
    ext_rise = ext_level & ~r.clk_prev;
    ext_fall = ~ext_level & r.clk_prev;
    // instruction clock stops during sleep
    q_en = (r.qdiv == QDIV_LAST) & ~sleep_in;
    // prescaler terminal value 0, 1, 3 or 7
    ps_last = 3'((4'h1 << ps_sel) - 4'h1);
    addr_phase = hsel_in & htrans_in[1] & hready_in;
  end

  // counting, register writes and bus answer
  always_comb begin
    next_r = r;
    tick = 1'b0;
    rollover = 1'b0;
    wr_count = 1'b0;
    rd_word = 32'h0000_0000;
    next_r.qdiv = sleep_in ? r.qdiv : 2'(r.qdiv + 2'h1);
    next_r.clk_prev = ext_level;

    // arming on a falling edge before the first rising edge
    if (!use_ext || !timer_on) begin
      next_r.armed = 1'b0;
      next_r.sync_pend = 1'b0;
    end else if (ext_fall) begin
      next_r.armed = 1'b1;
    end

    // select the increment source
    if (!use_ext) begin
      tick = q_en & run;
    end else if (free_run) begin
      // free mode keeps counting while asleep
      tick = ext_rise & r.armed & run;
    end else begin
      // synchronised mode waits for the instruction clock
      if (ext_rise && r.armed && run) begin
        next_r.sync_pend = 1'b1;
      end
      if (q_en && (r.sync_pend || (ext_rise && r.armed && run))) begin
        tick = 1'b1;
        next_r.sync_pend = 1'b0;
      end
    end

    // prescale counter then the 16-bit pair
    if (tick) begin
      if (r.prescale >= ps_last) begin
        next_r.prescale = 3'h0;
        next_r.count = 16'(r.count + 16'h0001);
        rollover = (r.count == COUNT_MAX);
      end else begin
        next_r.prescale = 3'(r.prescale + 3'h1);
      end
    end

    // data phase of a write; a count write beats the increment
    if (r.wr_pend) begin
      case (r.wr_addr)
        OFS_COUNT_LOW: begin
          next_r.count[7:0] = hwdata_in[7:0];
          wr_count = 1'b1;
        end
        OFS_COUNT_HIGH: begin
          next_r.count[15:8] = hwdata_in[7:0];
          wr_count = 1'b1;
        end
        OFS_COMP_CTRL: begin
          next_r.gate_source_select = hwdata_in[BIT_GATE_SOURCE];
        end
        OFS_TIMER_CONTROL: begin
          next_r.timer_control = hwdata_in[7:0];
        end
        OFS_IRQ_MASK: begin
          next_r.rollover_irq_enable = hwdata_in[BIT_ROLLOVER];
        end
        OFS_IRQ_CONTROL: begin
          next_r.periph_enable = hwdata_in[BIT_PERIPH_ENABLE];
          next_r.global_enable = hwdata_in[BIT_GLOBAL_ENABLE];
        end
        default: begin
        end
      endcase
    end
    // any count byte write restarts the prescaler
    if (wr_count) begin
      next_r.prescale = 3'h0;
    end

    // sticky flag: write one clears, a new rollover wins
    if (r.wr_pend && (r.wr_addr == OFS_IRQ_STATUS) && hwdata_in[BIT_ROLLOVER]) begin
      next_r.rollover_flag = 1'b0;
    end
    if (rollover && !wr_count) begin
      next_r.rollover_flag = 1'b1;
    end

    // read word from post-write values; the count is already in this
    // domain so a read never sees a half-updated pair
    case (haddr_in)
      OFS_COUNT_LOW: rd_word[7:0] = next_r.count[7:0];
      OFS_COUNT_HIGH: rd_word[7:0] = next_r.count[15:8];
      OFS_COMP_CTRL: rd_word[BIT_GATE_SOURCE] = next_r.gate_source_select;
      OFS_IRQ_STATUS: rd_word[BIT_ROLLOVER] = next_r.rollover_flag;
      OFS_TIMER_CONTROL: rd_word[7:0] = next_r.timer_control;
      OFS_IRQ_MASK: rd_word[BIT_ROLLOVER] = next_r.rollover_irq_enable;
      OFS_IRQ_CONTROL: begin
        rd_word[BIT_PERIPH_ENABLE] = next_r.periph_enable;
        rd_word[BIT_GLOBAL_ENABLE] = next_r.global_enable;
      end
      default: rd_word = 32'h0000_0000;
    endcase

    // address phase: latch write target, load read data
    next_r.wr_pend = addr_phase & hwrite_in;
    next_r.wr_addr = haddr_in;
    if (addr_phase && !hwrite_in) begin
      next_r.hrdata = rd_word;
    end
    next_r.hreadyout = 1'b1;

    // interrupt needs the flag and all three enables
    next_r.irq = next_r.rollover_flag & next_r.rollover_irq_enable
                 & next_r.periph_enable & next_r.global_enable;
    // wake from sleep without the global enable
    next_r.wake = sleep_in & next_r.rollover_flag & next_r.rollover_irq_enable
                  & next_r.periph_enable;
    next_r.lp_en = next_r.timer_control[BIT_LP_OSC_ENABLE]
                   & internal_oscillator_no_clkout_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
      r.timer_control <= RST_TIMER_CONTROL;
      r.count <= RST_COUNT;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register; the bus response is tied to okay
  assign hrdata_out = r.hrdata;
  assign hreadyout_out = r.hreadyout;
  assign hresp_out = 1'b0;
  assign irq_out = r.irq;
  assign wake_out = r.wake;
  assign lp_osc_enable_out = r.lp_en;
endmodule // gtc_timer
`default_nettype wire

// ### gtc_timer_properties.sv
// gtc_timer_properties: bus and interrupt relations at the timer's ports.
// assumes one clock domain and zero-wait word transfers on the bus.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_properties
  import gtc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // bus
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // core side
  input wire logic sleep_in,
  input wire logic internal_oscillator_no_clkout_in,
  input wire logic irq_out,
  input wire logic wake_out,
  input wire logic lp_osc_enable_out
);
  logic dp_rd, dp_wr, msk, pe, ge;
  logic [7:0] dp_a, ctl;
  wire logic take = hsel_in && htrans_in[1] && hready_in;
  // data phase tracking and shadow of written enables
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      {dp_rd, dp_wr, dp_a, ctl, msk, pe, ge} <= '0;
    end else begin
      dp_rd <= take && !hwrite_in;
      dp_wr <= take && hwrite_in;
      if (take) dp_a <= haddr_in;
      if (dp_wr && dp_a == OFS_TIMER_CONTROL) ctl <= hwdata_in[7:0];
      if (dp_wr && dp_a == OFS_IRQ_MASK) msk <= hwdata_in[0];
      if (dp_wr && dp_a == OFS_IRQ_CONTROL) {ge, pe} <= hwdata_in[7:6];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  AST_OKAY: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  AST_NO_WAIT: assert property (hreadyout_out)
    else $error("wait state inserted");
  AST_CTRL_READ: assert property (
    dp_rd && dp_a == OFS_TIMER_CONTROL |-> hrdata_out == {24'h0, ctl})
    else $error("control readback differs from last write");
  AST_UNMAPPED: assert property (dp_rd && dp_a >= 8'h1C |-> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_BYTE_WIDE: assert property (
    dp_rd && dp_a <= OFS_COUNT_HIGH |-> hrdata_out[31:8] == 24'h0)
    else $error("count byte has upper bits set");
  // enable shadows and registered outputs move at the same edge
  AST_IRQ_ENABLES: assert property (irq_out |-> msk && pe && ge)
    else $error("interrupt without all enables");
  AST_WAKE: assert property (wake_out |-> $past(sleep_in) && msk && pe)
    else $error("wake without sleep or enables");
  AST_LP_OSC: assert property (
    lp_osc_enable_out == ($past(internal_oscillator_no_clkout_in) && ctl[3]))
    else $error("oscillator enable wrong");
  COV_IRQ: cover property (irq_out);
  COV_WAKE: cover property (wake_out);
  COV_LP: cover property (lp_osc_enable_out);
endmodule // gtc_timer_properties
bind gtc_timer gtc_timer_properties u_gtc_timer_properties (.clk_in, .srst_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
  .hresp_out, .sleep_in, .internal_oscillator_no_clkout_in, .irq_out, .wake_out,
  .lp_osc_enable_out);
`default_nettype wire

// ### gtc_pins.sv
// gtc_pins: pins around the timer: count clock, crystal, gate, comparator.
// assumes the bench calls pulse and set_gate; all edges are unclocked.
`timescale 1ns/10ps
`default_nettype none
module gtc_pins (
  // levels toward the timer
  output logic ext_pin_out,
  output logic lp_clk_out,
  output logic gate_n_out,
  output logic comp_out
);
  // idle: count pin low, gate pin high means inactive
  initial begin
    ext_pin_out = 1'b0;
    lp_clk_out = 1'b0;
    gate_n_out = 1'b1;
    comp_out = 1'b0;
  end
  // crystal runs free, also through sleep
  always #170 lp_clk_out = ~lp_clk_out;
  // from idle low the first edge is a rise, not yet counted;
  // called on a clock edge, every pin edge lands mid-cycle
  task automatic pulse(input int n);
    #10;
    repeat (n) begin
      #120 ext_pin_out = 1'b1;
      #140 ext_pin_out = 1'b0;
    end
  endtask
  // both gate sources take one level
  task automatic set_gate(input logic l);
    gate_n_out = l;
    comp_out = l;
  endtask
endmodule // gtc_pins
`default_nettype wire

// ### tb_gated_16bit_timer_counter.sv
// tb_gated_16bit_timer_counter: register-level tests of the gated timer.
// assumes zero-wait bus and the pin model in gtc_pins.
`timescale 1ns/10ps
`default_nettype none
module tb_gated_16bit_timer_counter;
  import gtc_pkg::*;
  logic clk_in, srst_in, hsel_in, hwrite_in, sleep_in, internal_oscillator_no_clkout_in, act;
  logic [7:0] haddr_in;
  logic [1:0] htrans_in;
  logic [31:0] hwdata_in, q;
  wire logic [31:0] hrdata_out;
  wire logic hreadyout_out, hresp_out, irq_out, wake_out, lp_osc_enable_out;
  wire logic ext_count_clock_pin_in, lp_osc_clock_in, gate_pin_n_in, comparator_two_output_in;
  int bad_count = 0;
  int n_compared = 0;
  gtc_timer u_gtc_timer (.clk_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
    .hresp_out, .ext_count_clock_pin_in, .lp_osc_clock_in, .gate_pin_n_in,
    .comparator_two_output_in, .sleep_in, .internal_oscillator_no_clkout_in, .irq_out,
    .wake_out, .lp_osc_enable_out);
  gtc_pins u_gtc_pins (.ext_pin_out(ext_count_clock_pin_in), .lp_clk_out(lp_osc_clock_in),
    .gate_n_out(gate_pin_n_in), .comp_out(comparator_two_output_in));
  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    r = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // load count, then control
  task automatic start(input logic [7:0] c, input logic [15:0] v);
    wr(OFS_COUNT_LOW, {24'h0, v[7:0]});
    wr(OFS_COUNT_HIGH, {24'h0, v[15:8]});
    wr(OFS_TIMER_CONTROL, {24'h0, c});
  endtask
  // stop, idle a while, read low byte
  task automatic stop_rd(output logic [31:0] r);
    wr(OFS_TIMER_CONTROL, 32'h0);
    repeat (40) @(posedge clk_in);
    bus(1'b0, OFS_COUNT_LOW, 32'h0, r);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    {srst_in, hsel_in, hwrite_in, sleep_in, internal_oscillator_no_clkout_in} = 5'h10;
    {haddr_in, htrans_in, hwdata_in} = '0;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    bus(1'b0, OFS_TIMER_CONTROL, 32'h0, q); chk(q, 32'h0);
    wr(OFS_TIMER_CONTROL, 32'hFF);
    bus(1'b0, OFS_TIMER_CONTROL, 32'h0, q); chk(q, 32'hFF);
    bus(1'b0, 8'h1C, 32'h0, q); chk(q, 32'h0);
    // prescale: about 32 ticks in 131 clocks
    for (int p = 0; p < 4; p++) begin
      start({2'h0, p[1:0], 4'h1}, 16'h0);
      repeat (128) @(posedge clk_in);
      stop_rd(q); rng(q, (32 >> p) - 1, (32 >> p) + 1);
    end
    start(8'h31, 16'h0);
    repeat (20) @(posedge clk_in);
    wr(OFS_COUNT_LOW, 32'h0);
    repeat (20) @(posedge clk_in);
    stop_rd(q); chk(q, 32'h0);
    // rollover and interrupt enables
    start(8'h01, 16'hFFFE);
    repeat (40) @(posedge clk_in);
    stop_rd(q);
    bus(1'b0, OFS_COUNT_HIGH, 32'h0, q); chk(q, 32'h0);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0, q); chk(q, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_IRQ_CONTROL, 32'h40);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 1'b0);
    wr(OFS_IRQ_CONTROL, 32'hC0);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 1'b1);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0, q); chk(q, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 1'b0);
    // external count: rise from idle ignored until a fall is seen
    for (int s = 0; s < 2; s++) begin
      start({5'h0, s[0], 2'h3}, 16'h0);
      repeat (40) @(posedge clk_in);
      u_gtc_pins.pulse(5);
      stop_rd(q); chk(q, 32'h4);
    end
    // gate: source, inversion, level; last pass without gate enable
    for (int i = 0; i < 9; i++) begin
      u_gtc_pins.set_gate(i[0]);
      wr(OFS_COMP_CTRL, {30'h0, i[2], 1'b0});
      act = (i[2] ? i[0] : ~i[0]) ^ i[1];
      start((i < 8) ? {i[1], 7'h41} : 8'h01, 16'h0);
      repeat (40) @(posedge clk_in);
      stop_rd(q);
      if (i < 8 && act) chk(q, 32'h0);
      else rng(q, 32'h9, 32'hB);
    end
    u_gtc_pins.set_gate(1'b1);
    // sleep: only free counting advances and wakes
    wr(OFS_IRQ_CONTROL, 32'h40);
    sleep_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      start(i ? 8'h03 : 8'h01, 16'h0);
      u_gtc_pins.pulse(3);
      stop_rd(q); chk(q, 32'h0);
    end
    start(8'h07, 16'hFFFF);
    u_gtc_pins.pulse(2);
    repeat (4) @(posedge clk_in);
    chk(wake_out, 1'b1);
    chk(irq_out, 1'b0);
    bus(1'b0, OFS_COUNT_LOW, 32'h0, q); chk(q, 32'h0);
    sleep_in <= 1'b0;
    wr(OFS_TIMER_CONTROL, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    // low-power oscillator enable follows the oscillator mode
    internal_oscillator_no_clkout_in <= 1'b1;
    wr(OFS_TIMER_CONTROL, 32'h08);
    repeat (3) @(posedge clk_in);
    chk(lp_osc_enable_out, 1'b1);
    // low-power clock replaces the idle pin as the count source
    start(8'h0F, 16'h0);
    repeat (100) @(posedge clk_in);
    stop_rd(q); rng(q, 32'h4, 32'h7);
    wr(OFS_TIMER_CONTROL, 32'h08);
    internal_oscillator_no_clkout_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(lp_osc_enable_out, 1'b0);
    print_verdict;
  end
endmodule // tb_gated_16bit_timer_counter
`default_nettype wire
